// >>> pkg/lip_pkg.sv
// Shared constants for the leveled interrupt priority unit.
// Assumes a single 25 MHz core clock and an APB slave with 32-bit data.
package lip_pkg;

   // ------------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------------
   localparam int NUM_SRC = 10;
   localparam int NUM_EXT = 4;
   localparam int NUM_INT = 6;
   localparam int ADDR_W = 8;
   localparam int CFG_W = 6;
   localparam int ISTAT_W = 3;

   // ------------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ISTAT = 8'h04;
   localparam logic [7:0] ADDR_IMASK = 8'h08;
   localparam logic [7:0] ADDR_VBASE = 8'h0C;
   localparam logic [7:0] ADDR_WSVC = 8'h10;
   localparam logic [7:0] ADDR_PEND = 8'h14;
   localparam logic [7:0] ADDR_CFG0 = 8'h40;
   localparam logic [7:0] ADDR_CFG_LAST = 8'h64;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CTRL_MAP_BIT = 0;
   localparam int CTRL_WSEL_LO = 1;
   localparam int CTRL_WEN_BIT = 3;
   localparam int CFG_LVL_LO = 0;
   localparam int CFG_PRI_LO = 3;
   localparam int CFG_AUTO_BIT = 5;
   localparam int ISTAT_WDOG = 0;
   localparam int ISTAT_ACK = 1;
   localparam int ISTAT_SPUR = 2;

   // ------------------------------------------------------------------
   // Source indices and levels
   // ------------------------------------------------------------------
   localparam int SRC_TOP = 3;
   localparam int SRC_WDOG = 6;
   localparam logic [2:0] LVL_NONE = 3'h0;
   localparam logic [2:0] LVL_NMI = 3'h7;
   localparam logic [11:0] EXT_LVL_ODD = 12'hF59;
   localparam logic [11:0] EXT_LVL_EVEN = 12'hFA2;

   // ------------------------------------------------------------------
   // Reset values and vector constants
   // ------------------------------------------------------------------
   localparam logic [5:0] CFG_RST = 6'h20;
   localparam logic [5:0] CFG_TOP_RST = 6'h3F;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] VBASE_RST = 32'h0000_0000;
   localparam logic [7:0] AUTOVEC_BASE = 8'h18;
   localparam int WDOG_TO_00_CLKS = 1024;
   localparam int WDOG_CNT_W = 14;

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DONE} lip_ack_e;

endpackage

// >>> src/lip_sync.sv
// Two-flop synchroniser bank for asynchronous request pins.
// Assumes the pins are unrelated to core_clk; output is a clean level.
`timescale 1ns/1ps
`default_nettype none
module lip_sync #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);

   // ------------------------------------------------------------------
   // Per-bit two-stage capture
   // ------------------------------------------------------------------
   logic [W-1:0] stage1Reg;

   // The first stage feeds only the second, so metastability cannot spread.
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            stage1Reg[i] <= 1'b1;
            syncOut[i] <= 1'b1;
         end else begin
            stage1Reg[i] <= asyncIn[i];
            syncOut[i] <= stage1Reg[i];
         end
      end
   end

endmodule
`default_nettype wire

// >>> src/lip_controller.sv
// Leveled interrupt priority unit: request arbitration, acknowledge, watchdog.
// Assumes an APB master on core_clk, active-low request pins from the board,
// same-clock internal requests and a core that signals instruction end.
`timescale 1ns/1ps
`default_nettype none
module lip_controller #(
   parameter int WDOG_BASE_CYCLES = lip_pkg::WDOG_TO_00_CLKS
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] extReqN,
   input wire logic timerOneReq,
   input wire logic timerTwoReq,
   input wire logic serialChannelOneReq,
   input wire logic serialChannelTwoReq,
   input wire logic twoWireBusReq,
   input wire logic [2:0] statusMask,
   input wire logic instrEnd,
   output logic [2:0] reqLevel,
   output logic ackActive,
   output logic [9:0] ackSrc,
   input wire logic srcVecValid,
   input wire logic [7:0] srcVector,
   output logic vecReady,
   output logic [7:0] vectorOut,
   output logic [31:0] handlerAddr,
   output logic wdogExpired,
   output logic irq
);

   // ------------------------------------------------------------------
   // Registers and shared signals
   // ------------------------------------------------------------------
   localparam int N = lip_pkg::NUM_SRC;
   logic [31:0] ctrl_reg;
   logic [31:0] vectorBase_reg;
   logic [lip_pkg::ISTAT_W-1:0] istat_reg, imask_reg, istatSet;
   logic [lip_pkg::CFG_W-1:0] cfg_reg [N];
   logic [N-1:0] pend_reg, srcReq, ackClr;
   // Per-source flag: pending at a level above the current winner's level.
   logic [N-1:0] outranks;
   logic [3:0] extReqSyncN;
   logic [2:0] lvl [N];
   logic [1:0] pri [N];
   logic [3:0] winIdx;
   logic [2:0] winLvl;
   logic winAuto, winValid, winPass;
   logic [3:0] ackIdx_reg;
   logic [2:0] ackLvl_reg;
   lip_pkg::lip_ack_e state_reg;
   logic wrEn, setupPh;
   logic [lip_pkg::WDOG_CNT_W-1:0] wdogCnt_reg, wdogLimit;

   // Pins come from the board, so they are resynchronised first.
   lip_sync #(.W(lip_pkg::NUM_EXT)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .asyncIn(extReqN),
      .syncOut(extReqSyncN)
   );

   // ------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------
   // Zero wait states: the access phase always completes in one cycle.
   assign pready = 1'b1;
   assign setupPh = psel && !penable;
   assign wrEn = psel && penable && pwrite;

   // Read data and error are captured in the setup phase for the access.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPh) begin
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (paddr == lip_pkg::ADDR_CTRL) begin
            prdata <= ctrl_reg;
         end else if (paddr == lip_pkg::ADDR_ISTAT) begin
            prdata[lip_pkg::ISTAT_W-1:0] <= istat_reg;
         end else if (paddr == lip_pkg::ADDR_IMASK) begin
            prdata[lip_pkg::ISTAT_W-1:0] <= imask_reg;
         end else if (paddr == lip_pkg::ADDR_VBASE) begin
            prdata <= vectorBase_reg;
         end else if (paddr == lip_pkg::ADDR_WSVC) begin
            prdata[lip_pkg::WDOG_CNT_W-1:0] <= wdogCnt_reg;
         end else if (paddr == lip_pkg::ADDR_PEND) begin
            prdata[N-1:0] <= pend_reg;
         end else if (paddr >= lip_pkg::ADDR_CFG0 && paddr <= lip_pkg::ADDR_CFG_LAST
                      && paddr[1:0] == 2'b00) begin
            prdata[lip_pkg::CFG_W-1:0] <= cfg_reg[4'((paddr - lip_pkg::ADDR_CFG0) >> 2)];
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // Control word: pin mapping, watchdog select and enable.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= lip_pkg::CTRL_RST;
      end else if (wrEn && paddr == lip_pkg::ADDR_CTRL) begin
         ctrl_reg <= pwdata & 32'h0000_000F;
      end
   end

   // The exception table can be moved by rewriting the base pointer.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vectorBase_reg <= lip_pkg::VBASE_RST;
      end else if (wrEn && paddr == lip_pkg::ADDR_VBASE) begin
         vectorBase_reg <= pwdata;
      end
   end

   // Per-source relative priority and autovector configuration; level for internal sources only.
   for (genvar i = 0; i < N; i++) begin : g_cfg
      localparam logic [7:0] CFG_ADDR = 8'(lip_pkg::ADDR_CFG0 + 4 * i);
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            cfg_reg[i] <= (i == lip_pkg::SRC_TOP) ? lip_pkg::CFG_TOP_RST : lip_pkg::CFG_RST;
         end else if (wrEn && paddr == CFG_ADDR) begin
            cfg_reg[i] <= pwdata[lip_pkg::CFG_W-1:0];
         end
      end
      assign pri[i] = cfg_reg[i][lip_pkg::CFG_PRI_LO +: 2];
      assign outranks[i] = pend_reg[i] && winValid && lvl[i] > winLvl;
      if (i < lip_pkg::NUM_EXT) begin : g_ext
         // Pins follow the group mapping; the top pin always sits at level 7.
         assign lvl[i] = ctrl_reg[lip_pkg::CTRL_MAP_BIT] ?
                         lip_pkg::EXT_LVL_EVEN[3*i +: 3] :
                         lip_pkg::EXT_LVL_ODD[3*i +: 3];
      end else begin : g_int
         assign lvl[i] = cfg_reg[i][lip_pkg::CFG_LVL_LO +: 3];
      end
   end

   // ------------------------------------------------------------------
   // Request collection and pending state
   // ------------------------------------------------------------------
   // Source order: four pins, timer one, timer two, watchdog, serial, bus.
   assign srcReq = {twoWireBusReq, serialChannelTwoReq, serialChannelOneReq,
                    wdogExpired, timerTwoReq, timerOneReq, ~extReqSyncN};

   // A live request wins over the clear, so nothing is lost at acknowledge.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~ackClr) | srcReq;
      end
   end

   // ------------------------------------------------------------------
   // Arbitration
   // ------------------------------------------------------------------
   // Highest level first, then relative priority; level 0 never requests.
   always_comb begin
      winIdx = 4'h0;
      winLvl = lip_pkg::LVL_NONE;
      winValid = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (pend_reg[i] && lvl[i] != lip_pkg::LVL_NONE &&
             (!winValid || {lvl[i], pri[i]} > {winLvl, pri[winIdx]})) begin
            winIdx = 4'(i);
            winLvl = lvl[i];
            winValid = 1'b1;
         end
      end
   end

   // Level 7 bypasses the mask, which makes the top line non-maskable.
   assign winPass = winValid && (winLvl > statusMask || winLvl == lip_pkg::LVL_NMI);
   assign winAuto = cfg_reg[winIdx][lip_pkg::CFG_AUTO_BIT];
   assign reqLevel = winPass ? winLvl : lip_pkg::LVL_NONE;

   // ------------------------------------------------------------------
   // Acknowledge sequence
   // ------------------------------------------------------------------
   // The winner is frozen at instruction end so a late arrival cannot swap it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= lip_pkg::ST_IDLE;
         ackIdx_reg <= 4'h0;
         ackLvl_reg <= lip_pkg::LVL_NONE;
      end else begin
         case (state_reg)
            lip_pkg::ST_IDLE: begin
               if (instrEnd && winPass) begin
                  ackIdx_reg <= winIdx;
                  ackLvl_reg <= winLvl;
                  state_reg <= winAuto ? lip_pkg::ST_DONE : lip_pkg::ST_FETCH;
               end
            end
            lip_pkg::ST_FETCH: begin
               if (srcVecValid) begin
                  state_reg <= lip_pkg::ST_DONE;
               end
            end
            default: begin
               state_reg <= lip_pkg::ST_IDLE;
            end
         endcase
      end
   end

   assign ackActive = state_reg != lip_pkg::ST_IDLE;
   assign ackSrc = (state_reg == lip_pkg::ST_FETCH) ? (N'(1) << ackIdx_reg) : '0;
   assign ackClr = (state_reg == lip_pkg::ST_DONE) ? (N'(1) << ackIdx_reg) : '0;

   // Vector and handler address; autovector uses a fixed entry per level.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vectorOut <= 8'h00;
         handlerAddr <= 32'h0000_0000;
         vecReady <= 1'b0;
      end else begin
         vecReady <= 1'b0;
         if (state_reg == lip_pkg::ST_IDLE && instrEnd && winPass && winAuto) begin
            vectorOut <= lip_pkg::AUTOVEC_BASE + 8'(winLvl);
            handlerAddr <= vectorBase_reg + {22'h0, 8'(winLvl), 2'b00} +
                           {22'h0, lip_pkg::AUTOVEC_BASE, 2'b00};
         end else if (state_reg == lip_pkg::ST_FETCH && srcVecValid) begin
            vectorOut <= srcVector;
            handlerAddr <= vectorBase_reg + {22'h0, srcVector, 2'b00};
         end
         if (state_reg == lip_pkg::ST_DONE) begin
            vecReady <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------------
   // Each select step doubles the time-out; 00 gives the base count.
   assign wdogLimit = lip_pkg::WDOG_CNT_W'(WDOG_BASE_CYCLES - 1) <<
                      ctrl_reg[lip_pkg::CTRL_WSEL_LO +: 2] |
                      ((lip_pkg::WDOG_CNT_W'(1) << ctrl_reg[lip_pkg::CTRL_WSEL_LO +: 2]) -
                       lip_pkg::WDOG_CNT_W'(1));

   // Any write to the service word, or clearing the enable bit, restarts the count; expiry holds until then.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdogCnt_reg <= '0;
         wdogExpired <= 1'b0;
      end else if (!ctrl_reg[lip_pkg::CTRL_WEN_BIT] ||
                   (wrEn && paddr == lip_pkg::ADDR_WSVC)) begin
         wdogCnt_reg <= '0;
         wdogExpired <= 1'b0;
      end else if (wdogCnt_reg == wdogLimit) begin
         wdogExpired <= 1'b1;
      end else begin
         wdogCnt_reg <= wdogCnt_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Block interrupt status
   // ------------------------------------------------------------------
   assign istatSet = {state_reg == lip_pkg::ST_IDLE && instrEnd && !winPass,
                      state_reg == lip_pkg::ST_DONE,
                      wdogExpired && wdogCnt_reg == wdogLimit};

   // Write-one-to-clear, with a same-cycle event taking precedence.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         istat_reg <= '0;
         imask_reg <= '0;
      end else begin
         if (wrEn && paddr == lip_pkg::ADDR_ISTAT) begin
            istat_reg <= (istat_reg & ~pwdata[lip_pkg::ISTAT_W-1:0]) | istatSet;
         end else begin
            istat_reg <= istat_reg | istatSet;
         end
         if (wrEn && paddr == lip_pkg::ADDR_IMASK) begin
            imask_reg <= pwdata[lip_pkg::ISTAT_W-1:0];
         end
      end
   end

   assign irq = |(istat_reg & imask_reg);

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // No pending source may sit at a higher level than the one that won.
   level_win_a: assert property (outranks == '0)
      else $error("Lower level won over a pending higher one.");
   mask_gate_a: assert property (reqLevel != lip_pkg::LVL_NONE |->
      (reqLevel > statusMask || reqLevel == lip_pkg::LVL_NMI))
      else $error("Masked level presented to core.");
   ack_start_a: assert property (state_reg == lip_pkg::ST_IDLE && instrEnd
      && winPass |=> ackActive && ackLvl_reg == $past(winLvl))
      else $error("Acknowledge did not start.");
   fetch_wait_a: assert property (state_reg == lip_pkg::ST_FETCH && srcVecValid
      |=> state_reg == lip_pkg::ST_DONE ##1 vecReady && vectorOut == $past(srcVector, 2))
      else $error("Supplied vector not forwarded.");
   auto_vec_a: assert property (state_reg == lip_pkg::ST_IDLE && instrEnd && winPass
      && winAuto |=> ##1 vecReady && vectorOut == lip_pkg::AUTOVEC_BASE + 8'($past(winLvl, 2)))
      else $error("Autovector entry wrong.");
   top_map_a: assert property (lvl[lip_pkg::SRC_TOP] == lip_pkg::LVL_NMI)
      else $error("Top pin not at level seven.");
   nmi_pass_a: assert property (pend_reg[lip_pkg::SRC_TOP]
      && winLvl == lip_pkg::LVL_NMI |-> reqLevel == lip_pkg::LVL_NMI)
      else $error("Non-maskable request blocked.");
   pend_hold_a: assert property (pend_reg[winIdx] && state_reg == lip_pkg::ST_IDLE
      |=> pend_reg[$past(winIdx)])
      else $error("Pending dropped without acknowledge.");
   vbase_addr_a: assert property (vecReady |-> handlerAddr ==
      vectorBase_reg + {22'h0, vectorOut, 2'b00})
      else $error("Handler address not base plus vector.");
   wdog_exp_a: assert property ($rose(wdogExpired) |->
      $past(wdogCnt_reg) == wdogLimit)
      else $error("Watchdog expired at wrong count.");
   wdog_src_a: assert property (wdogExpired |=> pend_reg[lip_pkg::SRC_WDOG])
      else $error("Watchdog request not pending.");

   autovec_c: cover property (vecReady && state_reg == lip_pkg::ST_IDLE && winAuto);
   fetch_c: cover property (state_reg == lip_pkg::ST_FETCH ##1 state_reg == lip_pkg::ST_DONE);
   nmi_c: cover property (reqLevel == lip_pkg::LVL_NMI && statusMask == lip_pkg::LVL_NMI);
   wdog_c: cover property ($rose(wdogExpired));

endmodule
`default_nettype wire

// >>> verification/lip_source_model.sv
// Far-side model of a vectoring request source answering vector fetches.
// Assumes ackSrc is one-hot and stays high until srcVecValid is sampled.
`timescale 1ns/1ps
`default_nettype none
module lip_source_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [9:0] ackSrc,
   input wire logic [3:0] delay,
   output logic srcVecValid,
   output logic [7:0] srcVector
);
   logic [3:0] waitCnt;
   // ------------------------------------------------------------------
   // Vector answer
   // ------------------------------------------------------------------
   // Only a source that is asked answers, so autovectored ones stay silent.
   // Idle data toggles every cycle so a stale vector can never look right.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         srcVecValid <= 1'b0;
         srcVector <= 8'hFF;
         waitCnt <= 4'h0;
      end else if (srcVecValid) begin
         srcVecValid <= 1'b0;
         srcVector <= ~srcVector;
         waitCnt <= 4'h0;
      end else if (|ackSrc && waitCnt == delay) begin
         srcVecValid <= 1'b1;
         srcVector <= 8'h40 + 8'($clog2(ackSrc));
      end else if (|ackSrc) begin
         waitCnt <= waitCnt + 4'h1;
      end else begin
         srcVector <= ~srcVector;
      end
   end
endmodule
`default_nettype wire

// >>> verification/leveled_interrupt_priority_unit_tb.sv
// Directed testbench for the interrupt priority unit over APB.
// Assumes the source model answers fetches; watchdog base shortened to 16.
`timescale 1ns/1ps
`default_nettype none
module leveled_interrupt_priority_unit_tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic timerOneReq, timerTwoReq, instrEnd, srcVecValid, vecReady;
   logic ackActive, wdogExpired, irq, serOneReq, serTwoReq, busReq;
   logic [7:0] paddr, srcVector, vectorOut;
   logic [31:0] pwdata, prdata, handlerAddr, rd;
   logic [3:0] extReqN, mdlDelay;
   logic [2:0] statusMask, reqLevel;
   logic [9:0] ackSrc;
   int mismatches, nCompared, cycles, n;

   lip_controller #(.WDOG_BASE_CYCLES(16)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .extReqN(extReqN),
      .timerOneReq(timerOneReq), .timerTwoReq(timerTwoReq), .serialChannelOneReq(serOneReq),
      .serialChannelTwoReq(serTwoReq), .twoWireBusReq(busReq), .statusMask(statusMask),
      .instrEnd(instrEnd), .reqLevel(reqLevel), .ackActive(ackActive), .ackSrc(ackSrc),
      .srcVecValid(srcVecValid), .srcVector(srcVector), .vecReady(vecReady),
      .vectorOut(vectorOut), .handlerAddr(handlerAddr), .wdogExpired(wdogExpired),
      .irq(irq));
   lip_source_model u_src (.core_clk(core_clk), .rst_n(rst_n), .ackSrc(ackSrc),
      .delay(mdlDelay), .srcVecValid(srcVecValid), .srcVector(srcVector));

   // Clock of 40 ns and a hang guard well above the expected run length.
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One APB transfer; request held until pready is seen at an access edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check("prdata", exp, rd);
   endtask
   // Outputs are sampled on the falling edge, clear of the launch edge.
   task automatic chkLvl(input logic [2:0] exp);
      @(negedge core_clk);
      check("reqLevel", {29'h0, exp}, {29'h0, reqLevel});
      @(posedge core_clk);
   endtask
   task automatic chkIrq(input logic exp);
      @(negedge core_clk);
      check("irq", {31'h0, exp}, {31'h0, irq});
      @(posedge core_clk);
   endtask
   task automatic pin(input logic [3:0] v);
      extReqN <= v;
      repeat (4) @(posedge core_clk);
      extReqN <= 4'hF;
   endtask
   task automatic ack(input logic [7:0] v);
      instrEnd <= 1'b1;
      @(posedge core_clk);
      instrEnd <= 1'b0;
      @(negedge core_clk);
      check("ackActive", 32'h1, {31'h0, ackActive});
      while (vecReady !== 1'b1) @(negedge core_clk);
      check("vectorOut", {24'h0, v}, {24'h0, vectorOut});
      check("handlerAddr", 32'h0000_1000 + {22'h0, v, 2'b00}, handlerAddr);
      @(posedge core_clk);
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      {core_clk, rst_n, psel, penable, pwrite, timerOneReq, timerTwoReq, instrEnd} = '0;
      {paddr, pwdata, statusMask, mdlDelay, cycles, mismatches, nCompared} = '0;
      {serOneReq, serTwoReq, busReq} = 3'b000;
      extReqN = 4'hF;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rdchk(lip_pkg::ADDR_CTRL, lip_pkg::CTRL_RST);
      rdchk(lip_pkg::ADDR_CFG0, {26'h0, lip_pkg::CFG_RST});
      rdchk(lip_pkg::ADDR_CFG0 + 8'h0C, {26'h0, lip_pkg::CFG_TOP_RST});
      apb(1'b0, 8'hFC, 32'h0);
      check("pslverr", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, lip_pkg::ADDR_VBASE, 32'h0000_1000);
      apb(1'b1, lip_pkg::ADDR_IMASK, 32'h0000_0006);
      statusMask <= 3'h3;
      pin(4'hD);
      chkLvl(3'h0);
      statusMask <= 3'h2;
      chkLvl(3'h3);
      ack(8'h1B);
      rdchk(lip_pkg::ADDR_PEND, 32'h0);
      chkIrq(1'b1);
      apb(1'b1, lip_pkg::ADDR_ISTAT, 32'h2);
      chkIrq(1'b0);
      statusMask <= 3'h7;
      pin(4'h7);
      chkLvl(3'h7);
      ack(8'h1F);
      instrEnd <= 1'b1;
      @(posedge core_clk);
      instrEnd <= 1'b0;
      @(posedge core_clk);
      rdchk(lip_pkg::ADDR_ISTAT, 32'h6);
      apb(1'b1, lip_pkg::ADDR_ISTAT, 32'h7);
      $display("test pins done");
      statusMask <= 3'h0;
      apb(1'b1, lip_pkg::ADDR_CFG0 + 8'h10, 32'h1D);
      apb(1'b1, lip_pkg::ADDR_CFG0 + 8'h14, 32'h15);
      timerOneReq <= 1'b1;
      timerTwoReq <= 1'b1;
      @(posedge core_clk);
      timerOneReq <= 1'b0;
      timerTwoReq <= 1'b0;
      rdchk(lip_pkg::ADDR_PEND, 32'h30);
      chkLvl(3'h5);
      ack(8'h44);
      rdchk(lip_pkg::ADDR_PEND, 32'h20);
      mdlDelay <= 4'h3;
      ack(8'h45);
      apb(1'b1, lip_pkg::ADDR_CTRL, 32'h1);
      pin(4'hE);
      chkLvl(3'h2);
      ack(8'h1A);
      apb(1'b1, lip_pkg::ADDR_CFG0 + 8'h24, 32'h26);
      {serOneReq, serTwoReq, busReq} <= 3'b111;
      @(posedge core_clk);
      {serOneReq, serTwoReq, busReq} <= 3'b000;
      rdchk(lip_pkg::ADDR_PEND, 32'h380);
      chkLvl(3'h6);
      ack(8'h1E);
      rdchk(lip_pkg::ADDR_PEND, 32'h180);
      $display("test priority done");
      apb(1'b1, lip_pkg::ADDR_ISTAT, 32'h7);
      apb(1'b1, lip_pkg::ADDR_IMASK, 32'h1);
      apb(1'b1, lip_pkg::ADDR_CTRL, 32'h8);
      n = 0;
      while (wdogExpired !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      check("wdogCycles", 32'h1, {31'h0, n >= 14 && n <= 18});
      chkIrq(1'b1);
      apb(1'b1, lip_pkg::ADDR_WSVC, 32'h0);
      apb(1'b1, lip_pkg::ADDR_CTRL, 32'h0);
      apb(1'b1, lip_pkg::ADDR_ISTAT, 32'h7);
      chkIrq(1'b0);
      $display("test watchdog done");
      finish_test();
   end
endmodule
`default_nettype wire
